// [verilog/fcts_map.vh]
/*
  command codes, cycle budgets and widths for the flash command timing sequencer.
  assumes inclusion by fcts_sequencer.v only.
*/
`ifndef FCTS_MAP_VH
`define FCTS_MAP_VH

// command codes
`define FCTS_CMD_VERIFY_ALL    8'h01
`define FCTS_CMD_VERIFY_BLOCK  8'h02
`define FCTS_CMD_VERIFY_PSECT  8'h03
`define FCTS_CMD_READ_ONCE     8'h04
`define FCTS_CMD_PROG_P        8'h06
`define FCTS_CMD_PROG_ONCE     8'h07
`define FCTS_CMD_ERASE_ALL     8'h08
`define FCTS_CMD_ERASE_PBLK    8'h09
`define FCTS_CMD_ERASE_PSECT   8'h0A
`define FCTS_CMD_UNSECURE      8'h0B
`define FCTS_CMD_KEY_VERIFY    8'h0C
`define FCTS_CMD_USER_MARGIN   8'h0D
`define FCTS_CMD_FIELD_MARGIN  8'h0E
`define FCTS_CMD_VERIFY_DSECT  8'h10
`define FCTS_CMD_PROG_D        8'h11
`define FCTS_CMD_ERASE_DSECT   8'h12

// bus-cycle budgets
`define FCTS_BUS_VERIFY_ALL    17'h08AAC
`define FCTS_BUS_VERIFY_PBLK   17'h082DC
`define FCTS_BUS_VERIFY_DBLK   17'h00AF0
`define FCTS_BUS_SECT_SETUP    17'h001C2
`define FCTS_BUS_READ_ONCE     17'h00190
`define FCTS_BUS_PROG_P        17'h007D0
`define FCTS_BUS_PROG_ONCE     17'h00866
`define FCTS_BUS_ERASE_ALL     17'h11170
`define FCTS_BUS_ERASE_PBLK    17'h105B8
`define FCTS_BUS_ERASE_SECT    17'h002BC
`define FCTS_BUS_KEY_VERIFY    17'h00190
`define FCTS_BUS_MARGIN        17'h0015E
`define FCTS_BUS_PROG_D_BASE   17'h001F4
`define FCTS_BUS_PROG_D_WORD   17'h0020D
`define FCTS_BUS_PROG_D_ROW    17'h00064
// bus-cycle setup before a sector scan
`define FCTS_BUS_SCAN_SETUP    17'h001C2

// units scanned by the whole-block checks
`define FCTS_SCAN_PBLK         16'h8000
`define FCTS_SCAN_DBLK         16'h0800

// operating-clock budgets
`define FCTS_OP_PROG_P         17'h000A4
`define FCTS_OP_ERASE_ALL      17'h18704
`define FCTS_OP_ERASE_PSECT    17'h04E34
`define FCTS_OP_ERASE_DSECT    17'h013A1
`define FCTS_OP_PROG_D_BASE    17'h0000E
`define FCTS_OP_PROG_D_WORD    17'h00036
`define FCTS_OP_PROG_D_ROW     17'h0000E

`define FCTS_CNT_W             17
`define FCTS_ZERO              17'h00000
`define FCTS_ONE               17'h00001

`endif

// [verilog/fcts_sequencer.v]
/*
  flash command timing sequencer: decodes a command code, scans or waits for the
  timed number of bus and operating-clock cycles, then reports completion.
  assumes a same-clock requester and a flash array that returns one blank flag per
  scanned unit on the same clock.
*/
`timescale 1ns/100ps
`include "fcts_map.vh"

module fcts_sequencer (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [7:0]  nvm_clock_divider,
  input  wire        cmd_valid,
  input  wire [7:0]  flash_command_code,
  input  wire        target_dflash,
  input  wire [15:0] unit_count,
  input  wire [2:0]  word_count,
  input  wire        row_cross,
  input  wire        blank_in,
  output wire        cmd_ready,
  output reg         busy,
  output reg         done,
  output reg         cmd_error,
  output reg         blank_fail,
  output reg         scan_active,
  output reg  [15:0] scan_addr,
  output reg         op_active,
  output reg         nvm_op_tick
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SETUP = 4'b0010;
  localparam [3:0] ST_SCAN = 4'b0100;
  localparam [3:0] ST_TIMED = 4'b1000;

  reg [3:0]              state_q;
  reg [3:0]              state_d;
  reg [7:0]              div_cnt_q;
  reg [`FCTS_CNT_W-1:0]  bus_cnt_q;
  reg [`FCTS_CNT_W-1:0]  op_cnt_q;
  reg [15:0]             scan_left_q;
  reg [`FCTS_CNT_W-1:0]  bus_need;
  reg [`FCTS_CNT_W-1:0]  op_need;
  reg                    scan_cmd;
  reg                    valid_cmd;
  reg [15:0]             scan_len;
  reg [`FCTS_CNT_W-1:0]  load_cnt;
  reg                    timed_last;
  wire                   launch;
  wire                   good_launch;
  wire                   bad_launch;

  function [`FCTS_CNT_W-1:0] times3;
    input [`FCTS_CNT_W-1:0] per;
    input [2:0]             n;
    begin
      times3 = (n[0] ? per : `FCTS_ZERO) + (n[1] ? {per[`FCTS_CNT_W-2:0], 1'b0} : `FCTS_ZERO)
             + (n[2] ? {per[`FCTS_CNT_W-3:0], 2'b00} : `FCTS_ZERO);
    end
  endfunction

  // setup part of a scan budget, never below one cycle
  function [`FCTS_CNT_W-1:0] budget_less;
    input [`FCTS_CNT_W-1:0] budget;
    input [15:0]            units;
    begin
      if (budget > {1'b0, units})
        budget_less = budget - {1'b0, units};
      else
        budget_less = `FCTS_ONE;
    end
  endfunction

  assign cmd_ready = (state_q == ST_IDLE);
  assign launch = cmd_valid & cmd_ready;
  assign good_launch = launch & valid_cmd;
  assign bad_launch = launch & ~valid_cmd;

  // budget lookup; frequency never checked
  always @* begin
    bus_need = `FCTS_ZERO;
    op_need = `FCTS_ZERO;
    scan_cmd = 1'b0;
    valid_cmd = 1'b1;
    scan_len = 16'h0000;
    load_cnt = `FCTS_ZERO;
    case (flash_command_code)
      `FCTS_CMD_VERIFY_ALL: begin
        bus_need = `FCTS_BUS_VERIFY_ALL;
        scan_cmd = 1'b1;
        scan_len = `FCTS_SCAN_PBLK;
        load_cnt = budget_less(bus_need, scan_len);
      end
      `FCTS_CMD_VERIFY_BLOCK: begin
        bus_need = target_dflash ? `FCTS_BUS_VERIFY_DBLK : `FCTS_BUS_VERIFY_PBLK;
        scan_cmd = 1'b1;
        scan_len = target_dflash ? `FCTS_SCAN_DBLK : `FCTS_SCAN_PBLK;
        load_cnt = budget_less(bus_need, scan_len);
      end
      `FCTS_CMD_VERIFY_PSECT, `FCTS_CMD_VERIFY_DSECT: begin
        bus_need = `FCTS_BUS_SECT_SETUP;
        scan_cmd = 1'b1;
        scan_len = unit_count;
        load_cnt = bus_need;
      end
      `FCTS_CMD_READ_ONCE: begin
        bus_need = `FCTS_BUS_READ_ONCE;
      end
      `FCTS_CMD_PROG_P: begin
        bus_need = `FCTS_BUS_PROG_P;
        op_need = `FCTS_OP_PROG_P;
      end
      `FCTS_CMD_PROG_ONCE: begin
        bus_need = `FCTS_BUS_PROG_ONCE;
        op_need = `FCTS_OP_PROG_P;
      end
      `FCTS_CMD_ERASE_ALL, `FCTS_CMD_UNSECURE: begin
        bus_need = `FCTS_BUS_ERASE_ALL;
        op_need = `FCTS_OP_ERASE_ALL;
      end
      `FCTS_CMD_ERASE_PBLK: begin
        bus_need = `FCTS_BUS_ERASE_PBLK;
        op_need = `FCTS_OP_ERASE_ALL;
      end
      `FCTS_CMD_ERASE_PSECT: begin
        bus_need = `FCTS_BUS_ERASE_SECT;
        op_need = `FCTS_OP_ERASE_PSECT;
      end
      `FCTS_CMD_KEY_VERIFY: begin
        bus_need = `FCTS_BUS_KEY_VERIFY;
      end
      `FCTS_CMD_USER_MARGIN, `FCTS_CMD_FIELD_MARGIN: begin
        bus_need = `FCTS_BUS_MARGIN;
      end
      `FCTS_CMD_PROG_D: begin
        bus_need = `FCTS_BUS_PROG_D_BASE + times3(`FCTS_BUS_PROG_D_WORD, word_count)
                 + (row_cross ? `FCTS_BUS_PROG_D_ROW : `FCTS_ZERO);
        op_need = `FCTS_OP_PROG_D_BASE + times3(`FCTS_OP_PROG_D_WORD, word_count)
                + (row_cross ? `FCTS_OP_PROG_D_ROW : `FCTS_ZERO);
      end
      `FCTS_CMD_ERASE_DSECT: begin
        bus_need = `FCTS_BUS_ERASE_SECT;
        op_need = `FCTS_OP_ERASE_DSECT;
      end
      default: begin
        valid_cmd = 1'b0;
      end
    endcase
    if (!scan_cmd)
      load_cnt = bus_need;
  end

  // divided tick, runs always
  always @(posedge core_clk) begin
    if (rst) begin
      div_cnt_q <= 8'h00;
      nvm_op_tick <= 1'b0;
    end else if (div_cnt_q >= nvm_clock_divider) begin
      div_cnt_q <= 8'h00;
      nvm_op_tick <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
      nvm_op_tick <= 1'b0;
    end
  end

  // last timed cycle: bus part spent, operating part spent or on its final tick
  always @* begin
    timed_last = 1'b0;
    if (op_cnt_q == `FCTS_ZERO && bus_cnt_q <= `FCTS_ONE)
      timed_last = 1'b1;
    if (op_cnt_q == `FCTS_ONE && bus_cnt_q == `FCTS_ZERO && nvm_op_tick)
      timed_last = 1'b1;
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (good_launch && scan_cmd)
          state_d = ST_SETUP;
        else if (good_launch)
          state_d = ST_TIMED;
      end
      ST_SETUP: begin
        if (bus_cnt_q <= `FCTS_ONE && scan_left_q == 16'h0000)
          state_d = ST_IDLE;
        else if (bus_cnt_q <= `FCTS_ONE)
          state_d = ST_SCAN;
      end
      ST_SCAN: begin
        if (!blank_in || scan_left_q <= 16'h0001)
          state_d = ST_IDLE;
      end
      ST_TIMED: begin
        if (timed_last)
          state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // bus part first, then the operating part, so the two times add up
  always @(posedge core_clk) begin
    if (rst) begin
      bus_cnt_q <= `FCTS_ZERO;
      op_cnt_q <= `FCTS_ZERO;
      scan_left_q <= 16'h0000;
      scan_addr <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (good_launch) begin
            bus_cnt_q <= load_cnt;
            op_cnt_q <= op_need;
            scan_left_q <= scan_len;
            scan_addr <= 16'h0000;
          end
        end
        ST_SETUP: begin
          bus_cnt_q <= bus_cnt_q - `FCTS_ONE;
        end
        ST_SCAN: begin
          scan_addr <= scan_addr + 16'h0001;
          scan_left_q <= scan_left_q - 16'h0001;
        end
        ST_TIMED: begin
          if (bus_cnt_q != `FCTS_ZERO)
            bus_cnt_q <= bus_cnt_q - `FCTS_ONE;
          else if (op_cnt_q != `FCTS_ZERO && nvm_op_tick)
            op_cnt_q <= op_cnt_q - `FCTS_ONE;
        end
        default: begin
          bus_cnt_q <= `FCTS_ZERO;
          op_cnt_q <= `FCTS_ZERO;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cmd_error <= 1'b0;
      blank_fail <= 1'b0;
      scan_active <= 1'b0;
      op_active <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            cmd_error <= bad_launch;
            done <= bad_launch;
            blank_fail <= 1'b0;
            busy <= good_launch;
            op_active <= good_launch & ~scan_cmd;
          end
        end
        ST_SETUP: begin
          if (state_d == ST_SCAN)
            scan_active <= 1'b1;
          if (state_d == ST_IDLE) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        ST_SCAN: begin
          if (state_d == ST_IDLE) begin
            blank_fail <= ~blank_in;
            scan_active <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        ST_TIMED: begin
          if (state_d == ST_IDLE) begin
            op_active <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: begin
          busy <= 1'b0;
          scan_active <= 1'b0;
          op_active <= 1'b0;
        end
      endcase
    end
  end

endmodule // fcts_sequencer

// [testbench/fcts_seq_assertions.sv]
/* port checker for fcts_sequencer.
   assumes one core_clk domain with synchronous active-high rst. */
`timescale 1ns/100ps
module fcts_seq_assertions (
  input wire        core_clk,
  input wire        rst,
  input wire [7:0]  nvm_clock_divider,
  input wire        cmd_valid,
  input wire [7:0]  flash_command_code,
  input wire        blank_in,
  input wire        cmd_ready,
  input wire        busy,
  input wire        done,
  input wire        cmd_error,
  input wire        blank_fail,
  input wire        scan_active,
  input wire [15:0] scan_addr,
  input wire        op_active,
  input wire        nvm_op_tick
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire launch    = cmd_valid && cmd_ready;
  wire short_cmd = flash_command_code inside {8'h04, 8'h0C, 8'h0D, 8'h0E};

  AST_BUSY_BLOCKS: assert property (busy |-> !cmd_ready)
    else $error("ready while busy");
  AST_LAUNCH: assert property (launch |=> busy || (done && cmd_error))
    else $error("launch not taken");
  AST_DONE_END: assert property ($fell(busy) |-> done)
    else $error("busy ended without done");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_TICK_PULSE: assert property ((nvm_op_tick && nvm_clock_divider != 8'h00) |=> !nvm_op_tick)
    else $error("tick not divided");
  AST_SCAN_ZERO: assert property ($rose(scan_active) |-> scan_addr == 16'h0000)
    else $error("scan not from zero");
  AST_SCAN_STEP: assert property ((scan_active && blank_in ##1 scan_active) |-> scan_addr == $past(scan_addr) + 16'h0001)
    else $error("scan step wrong");
  AST_NONBLANK_STOP: assert property ((scan_active && !blank_in) |-> ##[1:3] (done && blank_fail))
    else $error("scan kept on after non-blank");
  AST_SHORT_BOUND: assert property ((launch && short_cmd) |-> ##[1:401] done)
    else $error("short command too long");
  AST_OP_IN_BUSY: assert property (op_active |-> busy)
    else $error("op active while idle");

  cover property (launch && short_cmd);
  cover property (scan_active && !blank_in);
  cover property (done && cmd_error);
endmodule // fcts_seq_assertions

bind fcts_sequencer fcts_seq_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .nvm_clock_divider(nvm_clock_divider),
  .cmd_valid(cmd_valid), .flash_command_code(flash_command_code), .blank_in(blank_in),
  .cmd_ready(cmd_ready), .busy(busy), .done(done), .cmd_error(cmd_error),
  .blank_fail(blank_fail), .scan_active(scan_active), .scan_addr(scan_addr),
  .op_active(op_active), .nvm_op_tick(nvm_op_tick)
);

// [testbench/fcts_flash_model.sv]
/* flash array model: one blank flag per scanned unit.
   assumes scan_addr is valid while scan_active is high. */
`timescale 1ns/100ps
module fcts_flash_model (
  input  wire        core_clk,
  input  wire        scan_active,
  input  wire [15:0] scan_addr,
  input  wire [15:0] fail_addr,
  output reg         blank_in
);
  reg toggle_q = 1'b0;
  always @(posedge core_clk) toggle_q <= ~toggle_q;
  // junk outside a scan
  always @* blank_in = scan_active ? (scan_addr != fail_addr) : toggle_q;
endmodule // fcts_flash_model

// [testbench/fcts_sequencer_test.sv]
/* directed bench for fcts_sequencer with a flash array model.
   assumes 10 MHz core_clk and inputs driven on the falling edge. */
`timescale 1ns/100ps
module fcts_sequencer_test;
  reg         core_clk, rst, cmd_valid, target_dflash, row_cross;
  reg  [7:0]  nvm_clock_divider, flash_command_code;
  reg  [15:0] unit_count, fail_addr;
  reg  [2:0]  word_count;
  wire        blank_in, cmd_ready, busy, done, cmd_error, blank_fail;
  wire        scan_active, op_active, nvm_op_tick;
  wire [15:0] scan_addr;
  integer     err_count = 0, total_checks = 0, n, i;
  reg  [7:0]  codes [0:3];
  fcts_sequencer DUT (.core_clk(core_clk), .rst(rst), .nvm_clock_divider(nvm_clock_divider),
    .cmd_valid(cmd_valid), .flash_command_code(flash_command_code),
    .target_dflash(target_dflash), .unit_count(unit_count), .word_count(word_count),
    .row_cross(row_cross), .blank_in(blank_in), .cmd_ready(cmd_ready), .busy(busy),
    .done(done), .cmd_error(cmd_error), .blank_fail(blank_fail),
    .scan_active(scan_active), .scan_addr(scan_addr), .op_active(op_active),
    .nvm_op_tick(nvm_op_tick));
  fcts_flash_model u_flash (.core_clk(core_clk), .scan_active(scan_active),
    .scan_addr(scan_addr), .fail_addr(fail_addr), .blank_in(blank_in));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task check_rng(input string what, input integer lo, input integer hi);
    total_checks = total_checks + 1;
    if (n < lo || n > hi) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask
  task do_reset;
    @(negedge core_clk);
    rst = 1'b1;
    cmd_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
  endtask
  // launch, then count cycles to done; hold keeps a stray request up
  task run(input [7:0] code, input hold);
    @(negedge core_clk);
    flash_command_code = code;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    n = 1;
    if (hold) flash_command_code = 8'h05;
    else cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 40000) begin
      @(negedge core_clk);
      n = n + 1;
    end
    cmd_valid = 1'b0;
  endtask
  task t_short;
    codes[0] = 8'h0D; codes[1] = 8'h0E; codes[2] = 8'h04; codes[3] = 8'h0C;
    for (i = 0; i < 4; i = i + 1) begin
      run(codes[i], i == 0);
      check_rng("short time", i < 2 ? 351 : 401, i < 2 ? 351 : 401);
      if (i == 0) check_eq("stray taken", 32'h0, {31'h0, cmd_error});
    end
    run(8'h05, 1'b0);
    check_rng("unknown time", 1, 1);
    check_eq("unknown flag", 32'h1, {31'h0, cmd_error});
  endtask
  task t_timed;
    nvm_clock_divider = 8'h09;
    run(8'h06, 1'b0);
    check_rng("phrase time", 3632, 3641);
    nvm_clock_divider = 8'h00;
    run(8'h07, 1'b0);
    check_rng("once time", 2315, 2315);
    run(8'h12, 1'b0);
    check_rng("dsect erase", 5726, 5726);
    run(8'h0A, 1'b0);
    check_rng("psect erase", 20721, 20721);
    word_count = 3'h4;
    row_cross = 1'b1;
    run(8'h11, 1'b0);
    check_rng("dprog time", 2945, 2945);
  endtask
  task t_scan;
    unit_count = 16'h0014;
    run(8'h03, 1'b0);
    check_rng("psect verify", 471, 471);
    check_eq("blank ok", 32'h0, {31'h0, blank_fail});
    unit_count = 16'h000A;
    fail_addr = 16'h0005;
    run(8'h10, 1'b0);
    check_rng("dsect early", 457, 457);
    check_eq("blank fail", 32'h1, {31'h0, blank_fail});
    fail_addr = 16'hFFFF;
    target_dflash = 1'b1;
    run(8'h02, 1'b0);
    check_rng("dblock verify", 2801, 2801);
    run(8'h01, 1'b0);
    check_rng("all verify", 35501, 35501);
  endtask
  task t_erase;
    codes[0] = 8'h08; codes[1] = 8'h09; codes[2] = 8'h0A; codes[3] = 8'h0B;
    for (i = 0; i < 4; i = i + 1) begin
      @(negedge core_clk);
      flash_command_code = codes[i];
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      repeat (3) @(negedge core_clk);
      check_eq("erase running", 32'h3, {30'h0, busy, op_active});
      do_reset;
      check_eq("erase aborted", 32'h1, {30'h0, busy, cmd_ready});
    end
  endtask
  initial begin
    #10000000;
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    rst = 1'b1; cmd_valid = 1'b0; target_dflash = 1'b0; row_cross = 1'b0;
    nvm_clock_divider = 8'h00; flash_command_code = 8'h00;
    unit_count = 16'h0000; fail_addr = 16'hFFFF; word_count = 3'h1;
    do_reset;
    check_eq("reset state", 32'h00010000, {busy, done, cmd_ready, scan_addr});
    t_short;
    t_timed;
    t_scan;
    t_erase;
    end_sim;
  end
endmodule // fcts_sequencer_test
